// ### cpm_consts.svh
`ifndef CPM_CONSTS_SVH
`define CPM_CONSTS_SVH
// Register byte offsets on the AHB-Lite port.
`define OFS_SYSCLK   8'h00
`define OFS_PLL_CTRL 8'h04
`define OFS_PLL_STAT 8'h08
`define OFS_CLOCK_OUT_FUNCTION   8'h0c
`define OFS_CPU_DIV  8'h10
`define OFS_PER_EN   8'h14
`define OFS_PWR_CTRL 8'h18
`define OFS_WAKE_EN  8'h1c
`define OFS_PWR_STAT 8'h20
`define OFS_WKT_CTRL 8'h24
`define OFS_WKT_CNT  8'h28
`define OFS_GPREG0   8'h30
// Field positions.
`define PLL_PD_BIT   7
`define PWR_LOCK_BIT 4
`define PWR_WD_BIT   5
`define PWR_LP_BIT   6
`define WKT_SEL_BIT  0
`define WKT_FLAG_BIT 1
`define WKT_RUN_BIT  2
// Reset values.
`define RST_PLL_PD   1'b1
`define RST_CPU_DIV  8'h01
`define RST_PER_EN   32'hffff_ffff
// Timing: PLL settling time in ns and clock period in ns.
`define PLL_LOCK_NS  100000
`define CLK_PER_NS   10
`endif

// ### cpm_pkg.sv
package cpm_pkg;
  // System clock source, in register encoding order.
  typedef enum logic [1:0] {SRC_IRC, SRC_XTAL, SRC_WATCHDOG_OSC, SRC_PLL} clk_src_e;
  // Clock output source.
  typedef enum logic [1:0] {CKO_IRC, CKO_XTAL, CKO_WATCHDOG_OSC, CKO_MAIN} cko_e;
  // Reduced power mode requested on the next sleep request.
  typedef enum logic [1:0] {PM_SLEEP, PM_DSLEEP, PM_PDOWN, PM_DPD} pmode_e;
  // Power state.
  typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_DSLEEP, ST_PDOWN,
                            ST_DPD} pstate_e;
  // AHB-Lite request signals from the master.
  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
  } ahb_req_s;
  // Clock and power controls driven to the chip.
  typedef struct packed {
    logic        core_en;
    logic [31:0] per_clk;
    logic        irc_on;
    logic        irc_out_en;
    logic        xtal_on;
    logic        watchdog_osc_on;
    logic        lposc_on;
    logic        pll_pd;
    logic        pll_bypass;
    logic [4:0]  msel;
    logic [1:0]  psel;
    clk_src_e    sys_src;
    cko_e        cko_sel;
    logic [7:0]  cpu_div;
    logic        flash_stby;
    logic        flash_pd;
    logic        analog_pd;
    logic        dpd;
  } clk_ctl_s;
  // Wake-up timer state.
  typedef struct packed {
    logic [31:0] cnt;
    logic        run;
    logic        flag;
  } wkt_s;
endpackage

// ### self_wake_timer.sv
`timescale 1ns/1ps
// Always-on 32-bit down-counter that raises a timeout request.
module self_wake_timer
  import cpm_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        resetn,
  // Count ticks, one cycle each.
  input  wire logic        tick,
  // Load request and clear of the timeout flag.
  input  wire logic        load,
  input  wire logic [31:0] load_val,
  input  wire logic        clr_flag,
  // State seen by software.
  output logic     [31:0] count,
  output logic            running,
  output logic            timeout
);
  import cpm_pkg::*;

  wkt_s s_r;   // Registered state.
  wkt_s s_nxt; // Next state.

  // Next-state logic for load, count-down and timeout.
  always_comb
  begin
    s_nxt = s_r;
    if (!resetn)
    begin
      s_nxt = '0;
    end
    else if (load)
    begin
      // A non-zero load starts counting and drops the flag.
      s_nxt.cnt = load_val;
      s_nxt.run = (load_val != 32'h0);
      s_nxt.flag = (load_val != 32'h0) ? 1'b0 : s_r.flag;
    end
    else
    begin
      if (clr_flag)
      begin
        s_nxt.flag = 1'b0;
      end
      if (s_r.run && tick)
      begin
        s_nxt.cnt = s_r.cnt - 32'h1;
        if (s_r.cnt == 32'h1)
        begin
          // Stop at zero and hold the flag; a set beats a clear.
          s_nxt.run = 1'b0;
          s_nxt.flag = 1'b1;
        end
      end
    end
  end

  // State register.
  always_ff @(posedge clk)
  begin
    s_r <= s_nxt;
  end

  assign count = s_r.cnt;
  assign running = s_r.run;
  assign timeout = s_r.flag;

  // A non-zero load shows on the next edge as the count and a running timer.
  property p_load;
    @(posedge clk) disable iff (!resetn)
    load && load_val != 32'h0 |=> running && count == $past(load_val);
  endproperty
  a_load: assert property (p_load) else $error("load did not start");

  // A stopped count at zero keeps its flag until cleared or reloaded with a non-zero value.
  property p_hold;
    @(posedge clk) disable iff (!resetn)
    timeout && !clr_flag && !load |=> timeout && !running;
  endproperty
  a_hold: assert property (p_hold) else $error("timeout lost");

  // The last tick sets the flag on the next edge.
  property p_expire;
    @(posedge clk) disable iff (!resetn)
    running && tick && count == 32'h1 && !load |=> timeout && count == 32'h0;
  endproperty
  a_expire: assert property (p_expire) else $error("no timeout");
endmodule

// ### clock_power_mode_control.sv
`timescale 1ns/1ps
`include "cpm_consts.svh"
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module clock_power_mode_control
  import cpm_pkg::*;
#(
  // Cycles the PLL needs to settle after power-up.
  parameter int unsigned LOCK_CYC = `PLL_LOCK_NS / `CLK_PER_NS
)
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        resetn,
  // AHB-Lite slave port.
  input  wire logic        hsel,
  input  wire ahb_req_s    ahb_req,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic     [31:0]  hrdata,
  // Core sleep request and pending interrupt summary.
  input  wire logic        sleep_req,
  input  wire logic        irq_pend,
  // Wake sources: pin, watchdog, USART, SPI, I2C.
  input  wire logic [4:0]  wake_src,
  input  wire logic [4:0]  nested_interrupt_controller_en,
  input  wire logic        wake_pin_n,
  // Oscillator ticks for the wake-up timer.
  input  wire logic        lp_tick,
  input  wire logic        irc_tick,
  // Clock and power controls and the timer request.
  output clk_ctl_s         ctl,
  output logic             wkt_irq
);
  import cpm_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    clk_src_e        src;      // System clock source.
    cko_e            cko;      // Clock output source.
    logic [7:0]      cpu_div;  // CPU clock divider.
    logic [31:0]     per_en;   // Peripheral clock enables.
    logic            pll_pd;   // PLL power-down.
    logic [4:0]      msel;     // Feedback multiplier minus one.
    logic [1:0]      psel;     // Post-divider select.
    logic [15:0]     lock_cnt; // Settling counter.
    logic            locked;   // PLL settled.
    pmode_e          tgt;      // Mode entered on sleep request.
    logic            dpd_lock; // Deep power-down refused.
    logic            wd_keep;  // Watchdog oscillator kept in deep-sleep and power-down.
    logic            lp_keep;  // Low-power oscillator kept.
    logic            wkt_sel;  // Timer runs from the RC oscillator.
    logic [4:0]      wake_en;  // Wake-up enables.
    pstate_e         ps;       // Power state.
    logic [3:0][31:0] gpreg;   // Retention registers.
    logic            wr_pend;  // Write data phase pending.
    logic [7:0]      wr_ofs;   // Offset of the pending write.
    logic [31:0]     rdata;    // Read data.
    clk_ctl_s        ctl;      // Registered controls.
  } cpm_s;

  cpm_s        s_r;       // Registered state.
  cpm_s        s_nxt;     // Next state.
  logic        addr_ok;   // Address phase accepted.
  logic        wkt_ld;    // Timer load strobe.
  logic        wkt_clr;   // Timer flag clear strobe.
  logic        wkt_tick;  // Timer count enable.
  logic        wkt_run;   // Timer is counting.
  logic [31:0] wkt_cnt;   // Timer count.
  logic        wake_hit;  // Enabled wake source active.
  logic [31:0] wd;        // Write data.

  //////////////////////////////////////////////////////////////////////////
  // Bus decode and timer strobes.
  assign addr_ok = hsel && ahb_req.htrans[1] && hready;
  assign wd = ahb_req.hwdata;
  assign wkt_ld = s_r.wr_pend && s_r.wr_ofs == `OFS_WKT_CNT;
  assign wkt_clr = s_r.wr_pend && s_r.wr_ofs == `OFS_WKT_CTRL
                   && wd[`WKT_FLAG_BIT];
  // In deep power-down RC ticks are dropped, so an RC-timed timer stops counting.
  assign wkt_tick = s_r.wkt_sel ? (irc_tick && s_r.ps != ST_DPD)
                                : lp_tick;
  // A source wakes only with both enables set; the timer timeout needs none.
  assign wake_hit = |(wake_src & s_r.wake_en & nested_interrupt_controller_en) || wkt_irq;

  //////////////////////////////////////////////////////////////////////////
  // Wake-up timer.
  self_wake_timer u_wkt (
    .clk      (clk),
    .resetn   (resetn),
    .tick     (wkt_tick),
    .load     (wkt_ld),
    .load_val (wd),
    .clr_flag (wkt_clr),
    .count    (wkt_cnt),
    .running  (wkt_run),
    .timeout  (wkt_irq)
  );

  //////////////////////////////////////////////////////////////////////////
  // Next state: bus, PLL settling, power sequencing and controls.
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.wr_pend = addr_ok && ahb_req.hwrite;
    s_nxt.wr_ofs = ahb_req.haddr[7:0];
    // Register writes in the data phase.
    if (s_r.wr_pend)
    begin
      case (s_r.wr_ofs)
        // Source stays until software changes it.
        `OFS_SYSCLK:   s_nxt.src = clk_src_e'(wd[1:0]);
        `OFS_PLL_CTRL:
        begin
          // Five bits give multipliers one to thirty-two.
          s_nxt.msel = wd[4:0];
          // Two bits give only divide by 2, 4, 8, 16.
          s_nxt.psel = wd[6:5];
          s_nxt.pll_pd = wd[`PLL_PD_BIT];
          s_nxt.lock_cnt = 16'h0;
          s_nxt.locked = 1'b0;
        end
        `OFS_CLOCK_OUT_FUNCTION:   s_nxt.cko = cko_e'(wd[1:0]);
        `OFS_CPU_DIV:  s_nxt.cpu_div = wd[7:0];
        `OFS_PER_EN:   s_nxt.per_en = wd;
        `OFS_PWR_CTRL:
        begin
          s_nxt.tgt = pmode_e'(wd[1:0]);
          // The lock can only be set; reset clears it.
          s_nxt.dpd_lock = s_r.dpd_lock | wd[`PWR_LOCK_BIT];
          s_nxt.wd_keep = wd[`PWR_WD_BIT];
          s_nxt.lp_keep = wd[`PWR_LP_BIT];
        end
        `OFS_WAKE_EN:  s_nxt.wake_en = wd[4:0];
        `OFS_WKT_CTRL: s_nxt.wkt_sel = wd[`WKT_SEL_BIT];
        `OFS_GPREG0, `OFS_GPREG0 + 8'h4, `OFS_GPREG0 + 8'h8,
        `OFS_GPREG0 + 8'hc:
          s_nxt.gpreg[s_r.wr_ofs[3:2]] = wd;
        default: ;
      endcase
    end
    // Read data is captured in the address phase.
    s_nxt.rdata = 32'h0;
    if (addr_ok && !ahb_req.hwrite)
    begin
      case (ahb_req.haddr[7:0])
        `OFS_SYSCLK:   s_nxt.rdata[1:0] = s_r.src;
        `OFS_PLL_CTRL: s_nxt.rdata[7:0] = {s_r.pll_pd, s_r.psel, s_r.msel};
        `OFS_PLL_STAT: s_nxt.rdata[0] = s_r.locked;
        `OFS_CLOCK_OUT_FUNCTION:   s_nxt.rdata[1:0] = s_r.cko;
        `OFS_CPU_DIV:  s_nxt.rdata[7:0] = s_r.cpu_div;
        `OFS_PER_EN:   s_nxt.rdata = s_r.per_en;
        `OFS_PWR_CTRL: s_nxt.rdata[6:0] = {s_r.lp_keep, s_r.wd_keep,
                                           s_r.dpd_lock, 2'h0, s_r.tgt};
        `OFS_WAKE_EN:  s_nxt.rdata[4:0] = s_r.wake_en;
        `OFS_PWR_STAT: s_nxt.rdata[2:0] = s_r.ps;
        `OFS_WKT_CTRL: s_nxt.rdata[2:0] = {wkt_run, wkt_irq, s_r.wkt_sel};
        `OFS_WKT_CNT:  s_nxt.rdata = wkt_cnt;
        `OFS_GPREG0, `OFS_GPREG0 + 8'h4, `OFS_GPREG0 + 8'h8,
        `OFS_GPREG0 + 8'hc:
          s_nxt.rdata = s_r.gpreg[ahb_req.haddr[3:2]];
        default: s_nxt.rdata = 32'h0;
      endcase
    end
    // PLL settling count while powered.
    if (s_r.pll_pd || s_r.ps != ST_RUN && s_r.ps != ST_SLEEP)
    begin
      s_nxt.lock_cnt = 16'h0;
      s_nxt.locked = 1'b0;
    end
    else if (!s_r.locked)
    begin
      s_nxt.lock_cnt = s_r.lock_cnt + 16'h1;
      s_nxt.locked = (s_r.lock_cnt == 16'(LOCK_CYC - 1));
    end
    // Power state machine.
    case (s_r.ps)
      ST_RUN:
        if (sleep_req)
        begin
          case (s_r.tgt)
            PM_SLEEP:  s_nxt.ps = ST_SLEEP;
            PM_DSLEEP: s_nxt.ps = ST_DSLEEP;
            PM_PDOWN:  s_nxt.ps = ST_PDOWN;
            // Refused entry leaves the core running.
            PM_DPD:    s_nxt.ps = s_r.dpd_lock ? ST_RUN : ST_DPD;
            default:   s_nxt.ps = ST_RUN;
          endcase
        end
      // Any pending interrupt resumes execution from sleep; deep-sleep and power-down need wake_hit.
      ST_SLEEP:  if (irq_pend || wkt_irq) s_nxt.ps = ST_RUN;
      ST_DSLEEP: if (wake_hit) s_nxt.ps = ST_RUN;
      ST_PDOWN:  if (wake_hit) s_nxt.ps = ST_RUN;
      // Wake pin or timer timeout ends deep power-down.
      ST_DPD:    if (!wake_pin_n || wkt_irq) s_nxt.ps = ST_RUN;
      default:   s_nxt.ps = ST_RUN;
    endcase
    // Synchronous reset, before the controls follow the state.
    if (!resetn)
    begin
      s_nxt = '0;
      s_nxt.src = SRC_IRC;
      s_nxt.pll_pd = `RST_PLL_PD;
      s_nxt.cpu_div = `RST_CPU_DIV;
      s_nxt.per_en = `RST_PER_EN;
      s_nxt.ps = ST_RUN;
    end
    // Clock and power controls follow the next state.
    s_nxt.ctl.core_en = (s_nxt.ps == ST_RUN);
    // Peripherals keep their clocks in run and sleep only.
    s_nxt.ctl.per_clk = (s_nxt.ps == ST_RUN || s_nxt.ps == ST_SLEEP)
                        ? s_nxt.per_en : 32'h0;
    s_nxt.ctl.irc_on = (s_nxt.ps != ST_PDOWN && s_nxt.ps != ST_DPD)
                       || (s_nxt.wkt_sel && wkt_run);
    s_nxt.ctl.irc_out_en = (s_nxt.ps == ST_RUN || s_nxt.ps == ST_SLEEP);
    s_nxt.ctl.xtal_on = s_nxt.ctl.irc_out_en;
    s_nxt.ctl.watchdog_osc_on = s_nxt.ctl.irc_out_en
                         || (s_nxt.wd_keep && s_nxt.ps != ST_DPD);
    // Low-power clock stays for a running timer on the low-power source.
    s_nxt.ctl.lposc_on = s_nxt.lp_keep || (!s_nxt.wkt_sel && wkt_run);
    // Powered off and bypassed until enabled and settled.
    s_nxt.ctl.pll_pd = s_nxt.pll_pd || !s_nxt.ctl.irc_out_en;
    s_nxt.ctl.pll_bypass = s_nxt.pll_pd || !s_nxt.locked;
    s_nxt.ctl.msel = s_nxt.msel;
    // The post-divider sits in the loop to hold the band.
    s_nxt.ctl.psel = s_nxt.psel;
    s_nxt.ctl.sys_src = s_nxt.src;
    s_nxt.ctl.cko_sel = s_nxt.cko;
    s_nxt.ctl.cpu_div = s_nxt.cpu_div;
    s_nxt.ctl.flash_stby = (s_nxt.ps == ST_DSLEEP);
    s_nxt.ctl.flash_pd = (s_nxt.ps == ST_PDOWN || s_nxt.ps == ST_DPD);
    s_nxt.ctl.analog_pd = !s_nxt.ctl.irc_out_en;
    s_nxt.ctl.dpd = (s_nxt.ps == ST_DPD);
  end

  //////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clk)
  begin
    s_r <= s_nxt;
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data and controls from flip-flops, ready and response tied off; the slave never stalls or errs.
  logic ready_r; // Ready, low during reset and for one cycle after it.
  always_ff @(posedge clk)
  begin
    ready_r <= resetn;
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_r.rdata;
  assign ctl = s_r.ctl;

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  // After reset the RC clock runs and the PLL is off and bypassed.
  property p_rst;
    @(posedge clk) disable iff (!resetn)
    !ready_r |-> ctl.sys_src == SRC_IRC && ctl.pll_pd && ctl.pll_bypass;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset clocks");

  // Sleep stops the core clock and keeps peripheral clocks.
  property p_sleep;
    @(posedge clk) disable iff (!resetn)
    s_r.ps == ST_SLEEP |-> !ctl.core_en && ctl.per_clk == s_r.per_en;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep clocks");

  // Deep-sleep keeps the gated RC oscillator, stops crystal and PLL and puts flash by.
  property p_dsleep;
    @(posedge clk) disable iff (!resetn)
    s_r.ps == ST_DSLEEP |-> ctl.per_clk == 32'h0 && ctl.irc_on
      && !ctl.irc_out_en && !ctl.xtal_on && ctl.flash_stby && ctl.pll_pd;
  endproperty
  a_dsleep: assert property (p_dsleep) else $error("deep-sleep");

  // Power-down shuts flash and analog; RC only for an RC-timed timer.
  property p_pdown;
    @(posedge clk) disable iff (!resetn)
    s_r.ps == ST_PDOWN && !s_r.wkt_sel |-> !ctl.irc_on && ctl.flash_pd
      && ctl.analog_pd && !ctl.xtal_on;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power-down");

  // An enabled wake source brings deep-sleep and power-down back to run.
  property p_wake;
    @(posedge clk) disable iff (!resetn)
    (s_r.ps == ST_DSLEEP || s_r.ps == ST_PDOWN)
      && |(wake_src & s_r.wake_en & nested_interrupt_controller_en) |=> s_r.ps == ST_RUN;
  endproperty
  a_wake: assert property (p_wake) else $error("missed wake");

  // A source without its wake enable leaves the device asleep.
  property p_nowake;
    @(posedge clk) disable iff (!resetn)
    s_r.ps == ST_DSLEEP && !wkt_irq
      && (wake_src & s_r.wake_en & nested_interrupt_controller_en) == 5'h0 |=> s_r.ps == ST_DSLEEP;
  endproperty
  a_nowake: assert property (p_nowake) else $error("spurious wake");

  // Deep power-down is refused while the lock is set.
  property p_lock;
    @(posedge clk) disable iff (!resetn)
    s_r.ps == ST_RUN && sleep_req && s_r.tgt == PM_DPD && s_r.dpd_lock
      |=> s_r.ps == ST_RUN && !ctl.dpd;
  endproperty
  a_lock: assert property (p_lock) else $error("locked entry");

  // Wake pin or timeout leaves deep power-down one edge later.
  property p_dpd_exit;
    @(posedge clk) disable iff (!resetn)
    s_r.ps == ST_DPD && (!wake_pin_n || wkt_irq) |=> !ctl.dpd
      && ctl.core_en;
  endproperty
  a_dpd_exit: assert property (p_dpd_exit) else $error("no exit");

  // The PLL reports settled only after the full settling count.
  property p_settle;
    @(posedge clk) disable iff (!resetn)
    $rose(s_r.locked) |-> $past(s_r.lock_cnt) == 16'(LOCK_CYC - 1);
  endproperty
  a_settle: assert property (p_settle) else $error("early lock");
endmodule

// ### testbench.sv
`timescale 1ns/1ps
`include "cpm_consts.svh"
//////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the clock and power-mode controller.
module testbench;
  import cpm_pkg::*;
  // Compares a design value with the expected one and counts both.
  `define CHK(g, e) \
    begin \
      check_count++; \
      if ((g) !== (e)) \
      begin \
        n_fail++; \
        $display("wrong value t=%0t got %h exp %h", $time, (g), (e)); \
      end \
    end
  logic       clk, resetn, hsel, sleep_req, irq_pend; // Clock and controls.
  logic       wake_pin_n, lp_tick, irc_tick;          // Wake pin and ticks.
  logic [4:0] wake_src, nested_interrupt_controller_en;                      // Wake sources.
  ahb_req_s   req;                                    // Bus request.
  logic       hreadyout, hresp, wkt_irq;              // Design outputs.
  logic [31:0] hrdata, rd;                            // Read data.
  clk_ctl_s   ctl;                                    // Clock controls.
  int         n_fail, check_count, cyc;               // Counters.
  // Short settling count keeps the lock wait brief.
  clock_power_mode_control #(.LOCK_CYC(20)) dut_u (
    .clk(clk), .resetn(resetn), .hsel(hsel), .ahb_req(req),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sleep_req(sleep_req), .irq_pend(irq_pend),
    .wake_src(wake_src), .nested_interrupt_controller_en(nested_interrupt_controller_en), .wake_pin_n(wake_pin_n),
    .lp_tick(lp_tick), .irc_tick(irc_tick), .ctl(ctl), .wkt_irq(wkt_irq));
  //////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task close_out;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One single AHB-Lite transfer; read data is taken at the data edge.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    req.haddr <= {24'h0, a};
    req.htrans <= 2'b10;
    req.hwrite <= w;
    req.hsize <= 3'b010;
    do @(posedge clk); while (hreadyout !== 1'b1);
    req.htrans <= 2'b00;
    req.hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Write, then let the register updates land.
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    #1;
  endtask
  // Read into rd.
  task rdv(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  // One tick pulse from the RC (rc=1) or low-power source.
  task tick(input logic rc);
    @(posedge clk);
    irc_tick <= rc;
    lp_tick <= !rc;
    @(posedge clk);
    irc_tick <= 1'b0;
    lp_tick <= 1'b0;
    #1;
  endtask
  // Sets the target mode and pulses the sleep request once.
  task enter(input logic [31:0] pc);
    wr(`OFS_PWR_CTRL, pc);
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    #1;
  endtask
  // Waits a few cycles for the return to run mode.
  task wait_run;
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (ctl.core_en !== 1'b1 && k < 4);
    `CHK(ctl.core_en, 1'b1)
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Reset values, gates, divider and an unmapped read.
  task t_regs;
    rdv(`OFS_SYSCLK);
    `CHK({rd[1:0], ctl.sys_src}, {2'h0, SRC_IRC})
    rdv(`OFS_PLL_CTRL);
    `CHK({rd[7], ctl.pll_pd, ctl.pll_bypass}, 3'b111)
    rdv(`OFS_CPU_DIV);
    `CHK(rd, 32'h1)
    rdv(`OFS_PER_EN);
    `CHK(rd, 32'hffff_ffff)
    wr(`OFS_PER_EN, 32'h0000_00f0);
    wr(`OFS_CPU_DIV, 32'h3);
    `CHK({ctl.per_clk, ctl.cpu_div}, {32'h0000_00f0, 8'h03})
    wr(`OFS_PER_EN, 32'hffff_ffff);
    rdv(8'h2c);
    `CHK({rd, hresp}, 33'h0)
  endtask
  // PLL settings, lock wait and switch-over; every output source.
  task t_pll;
    wr(`OFS_PLL_CTRL, 32'h7f);
    `CHK({ctl.pll_pd, ctl.msel, ctl.psel}, 8'h7f)
    rdv(`OFS_PLL_STAT);
    `CHK(rd[0], 1'b0)
    repeat (25) @(posedge clk);
    rdv(`OFS_PLL_STAT);
    `CHK(rd[0], 1'b1)
    `CHK(ctl.pll_bypass, 1'b0)
    wr(`OFS_SYSCLK, 32'h3);
    `CHK(ctl.sys_src, SRC_PLL)
    for (int i = 0; i < 4; i++)
    begin
      wr(`OFS_CLOCK_OUT_FUNCTION, 32'(i));
      `CHK(ctl.cko_sel, cko_e'(i[1:0]))
    end
  endtask
  // Timer load, source select, timeout, hold at zero and clear.
  task t_timer;
    wr(`OFS_WKT_CTRL, 32'h1);
    wr(`OFS_WKT_CNT, 32'h3);
    tick(1'b1);
    tick(1'b1);
    rdv(`OFS_WKT_CNT);
    `CHK(rd, 32'h1)
    tick(1'b0);
    `CHK(wkt_irq, 1'b0)
    tick(1'b1);
    `CHK(wkt_irq, 1'b1)
    tick(1'b1);
    rdv(`OFS_WKT_CNT);
    `CHK(rd, 32'h0)
    rdv(`OFS_WKT_CTRL);
    `CHK(rd[2:0], 3'b011)
    wr(`OFS_WKT_CTRL, 32'h3);
    wr(`OFS_WKT_CNT, 32'h0);
    rdv(`OFS_WKT_CTRL);
    `CHK({wkt_irq, rd[2:0]}, 4'b0001)
  endtask
  // Sleep, then deep-sleep blocked, then deep-sleep and power-down in alternation, each source waking one of them in turn.
  task t_sleep;
    enter(32'h0);
    `CHK({ctl.core_en, ctl.per_clk}, {1'b0, 32'hffff_ffff})
    irq_pend <= 1'b1;
    wait_run;
    irq_pend <= 1'b0;
    wr(`OFS_WAKE_EN, 32'h2);
    wake_src <= 5'h02;
    enter(32'h1);
    `CHK(ctl.per_clk, 32'h0)
    `CHK({ctl.irc_out_en, ctl.flash_stby, ctl.xtal_on}, 3'b010)
    repeat (5) @(posedge clk);
    rdv(`OFS_PWR_STAT);
    `CHK(rd[2:0], 3'h2)
    wake_src <= 5'h00;
    nested_interrupt_controller_en <= 5'h1f;
    for (int i = 0; i < 5; i++)
    begin
      wr(`OFS_WAKE_EN, 32'h1 << i);
      enter(i[0] ? 32'h2 : 32'h1);
      wake_src <= 5'h1 << i;
      wait_run;
      wake_src <= 5'h00;
    end
  endtask
  // Power-down woken by the timer, then deep power-down and its lock.
  task t_down;
    wr(`OFS_WKT_CTRL, 32'h2);
    wr(`OFS_WKT_CNT, 32'h2);
    enter(32'h42);
    `CHK({ctl.flash_pd, ctl.analog_pd, ctl.xtal_on, ctl.irc_on}, 4'hc)
    `CHK({ctl.lposc_on, ctl.watchdog_osc_on}, 2'b10)
    tick(1'b0);
    tick(1'b0);
    wait_run;
    // Clear the timeout so only the wake pin can end deep power-down.
    wr(`OFS_WKT_CTRL, 32'h2);
    `CHK(wkt_irq, 1'b0)
    wr(`OFS_GPREG0 + 8'h0c, 32'h5a5a_0003);
    enter(32'h3);
    `CHK(ctl.dpd, 1'b1)
    repeat (3) @(posedge clk);
    #1;
    `CHK({ctl.dpd, ctl.core_en}, 2'b10)
    wake_pin_n <= 1'b0;
    wait_run;
    wake_pin_n <= 1'b1;
    rdv(`OFS_GPREG0 + 8'h0c);
    `CHK(rd, 32'h5a5a_0003)
    enter(32'h13);
    rdv(`OFS_PWR_STAT);
    `CHK({ctl.dpd, rd[2:0]}, 4'h0)
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Free-running clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Cuts a hang short.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      close_out;
    end
  end
  // Main sequence.
  initial
  begin
    {resetn, hsel, sleep_req, irq_pend, lp_tick, irc_tick} = '0;
    {wake_src, nested_interrupt_controller_en, req} = '0;
    wake_pin_n = 1'b1;
    {n_fail, check_count, cyc} = '0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_pll;
    t_timer;
    t_sleep;
    t_down;
    close_out;
  end
endmodule
